// ===== ast_pkg.sv
// Constants and field layouts shared by the serial core and its baud generator.
// Assumes a single bus clock; all registers are reached by a plain strobe port.
package ast_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int unsigned AW     = 2;
  localparam int unsigned DW     = 16;
  localparam int unsigned BAUD_W = 13;
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STAT = 2'h1;
  localparam logic [1:0] ADDR_DATA = 2'h2;
  localparam logic [1:0] ADDR_BAUD = 2'h3;

  // ----------------------------------------
  // Field layouts and reset values
  // ----------------------------------------
  typedef struct packed {
    logic two_stop_select;
    logic wide_char;
    logic long_break;
    logic break_request;
    logic rx_polarity_flip;
    logic tx_polarity_flip;
    logic rx_on;
    logic tx_on;
  } ast_ctrl_t;

  typedef struct packed {
    logic frame_fault;
    logic sample_disagree;
    logic overrun;
    logic rx_buffer_full;
    logic tx_done;
    logic tx_buffer_empty;
  } ast_stat_t;

  localparam ast_ctrl_t CTRL_RST = 8'h00;
  localparam ast_stat_t STAT_RST = 6'h03;
  localparam logic [BAUD_W-1:0] BAUD_RST = 13'h001A;

  // ----------------------------------------
  // Frame and sample slot timing
  // ----------------------------------------
  localparam logic [3:0] FRAME_BASE   = 4'hA;
  localparam logic [3:0] BREAK_EXTRA  = 4'h3;
  localparam logic [3:0] DATA_BASE    = 4'h8;
  localparam logic [3:0] SLOT_FIRST   = 4'h0;
  localparam logic [3:0] SLOT_START_A = 4'h2;
  localparam logic [3:0] SLOT_START_B = 4'h4;
  localparam logic [3:0] SLOT_START_C = 4'h6;
  localparam logic [3:0] SLOT_BIT_A   = 4'h7;
  localparam logic [3:0] SLOT_BIT_B   = 4'h8;
  localparam logic [3:0] SLOT_BIT_C   = 4'h9;
  localparam logic [3:0] SLOT_LAST    = 4'hF;
  localparam logic [1:0] LOWS_MIN     = 2'h2;
  localparam logic [2:0] HIGHS3       = 3'h7;

  typedef enum logic [1:0] {
    AST_RX_IDLE  = 2'b00,
    AST_RX_START = 2'b01,
    AST_RX_FRAME = 2'b10
  } ast_rx_t;

endpackage

// ===== ast_baud_gen.sv
// Baud generator: one sample slot tick per modulus bus clocks.
// Assumes the modulus is held steady by software; zero stops the ticks.
`timescale 1ns/100ps
module ast_baud_gen #(
  parameter int unsigned BW = ast_pkg::BAUD_W
) (
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic [BW-1:0] modulus,
  output logic               tick
);

  typedef struct packed {
    logic [BW-1:0] cnt;
    logic          tick;
  } ast_bg_state_t;

  ast_bg_state_t s_q;
  ast_bg_state_t s_d;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (modulus == '0) begin
      s_d.cnt = '0;
    end else if (s_q.cnt >= modulus - BW'(1)) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + BW'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

// ===== ast_core.sv
// Full-duplex asynchronous serial transmitter and receiver with register port.
// Assumes rxd is already synchronous to mclk and the master never strobes both ways.
//
// Functional notes
// - One bus-clock baud generator serves both directions
// - Output idles high; polarity flip inverts all
// - Turning transmitter on queues one idle preamble
// - Shifter length 10, 11 or 12 bits
// - Low start, LSB-first data, high stops
// - Free shifter loads buffer, sets buffer-empty flag
// - Nothing waiting after stop sets done flag
// - Turning transmitter off finishes pending frames first (code: a buffered character is not loaded until tx_on is set again)
// - Break is all zeros, 10 to 15 bits
// - Request one-then-zero queues break; held requeues
// - Off-then-on queues one idle frame
// - Receive polarity flip and receive enable
// - Completed character fills buffer or raises overrun
// - Sixteen sample slots per bit time
// - Edge is low after three highs
// - Start valid if two of slots 3,5,7 low
// - Bits decided by majority of slots 8-10
// - Accepted start bit always counts as low
// - Disagreeing samples set noise flag at load
// - Falling edges realign slot counter mid-frame
// - Non-break framing error preloads three highs
// - Frame fault set blocks buffer loads
// - Low stop majority flags framing error
// - Error flags follow buffer load, not overrun
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/100ps
module ast_core #(
  parameter int unsigned BW = ast_pkg::BAUD_W
) (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic [ast_pkg::AW-1:0] addr,
  input  wire logic [ast_pkg::DW-1:0] wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [ast_pkg::DW-1:0] rdata,
  input  wire logic                   rxd,
  output logic                        txd,
  output logic                        txd_oe
);

  typedef struct packed {
    ast_pkg::ast_ctrl_t  ctrl;
    ast_pkg::ast_stat_t  stat;
    logic [BW-1:0]       baud;
    logic [8:0]          tdr;
    logic [8:0]          rbuf;
    logic [11:0]         tsh;
    logic                tfill;
    logic [3:0]          tleft;
    logic [3:0]          tsub;
    logic                brk_q;
    logic                idle_q;
    logic                txd;
    logic                txd_oe;
    ast_pkg::ast_rx_t    rxs;
    logic [3:0]          rsub;
    logic [3:0]          ridx;
    logic [2:0]          hist;
    logic [1:0]          lows;
    logic [2:0]          votes;
    logic                noise;
    logic [8:0]          rsh;
    logic [ast_pkg::DW-1:0] rdata;
  } ast_state_t;

  ast_state_t s_q;
  ast_state_t s_d;

  logic       tick;
  logic       rxi;
  logic       fall;
  logic       bit_v;
  logic       rx_done;
  logic       start_fail;
  logic       tx_load_data;
  logic       tx_load_brk;
  logic       data_wr;
  logic [8:0] ch;
  ast_pkg::ast_stat_t clr;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] frame_len(input ast_pkg::ast_ctrl_t c);
    frame_len = ast_pkg::FRAME_BASE + {3'h0, c.wide_char} + {3'h0, c.two_stop_select};
  endfunction

  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // ----------------------------------------
  // Baud generator
  // ----------------------------------------
  // shared slot ticks
  ast_baud_gen #(.BW(BW)) u_baud (
    .mclk    (mclk),
    .rst     (rst),
    .modulus (s_q.baud),
    .tick    (tick)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.rdata    = '0;
    tx_load_data = 1'b0;
    tx_load_brk  = 1'b0;
    rx_done      = 1'b0;
    start_fail   = 1'b0;
    bit_v        = 1'b0;
    ch           = '0;
    data_wr      = wr && (addr == ast_pkg::ADDR_DATA);
    clr          = ast_pkg::ast_stat_t'(wdata[5:0]);
    rxi          = rxd ^ s_q.ctrl.rx_polarity_flip;
    fall         = (s_q.hist == ast_pkg::HIGHS3) && !rxi;

    if (wr) begin
      unique case (addr)
        ast_pkg::ADDR_CTRL: begin
          s_d.ctrl = ast_pkg::ast_ctrl_t'(wdata[7:0]);
        end
        ast_pkg::ADDR_STAT: begin
          s_d.stat.overrun         = s_q.stat.overrun & ~clr.overrun;
          s_d.stat.sample_disagree = s_q.stat.sample_disagree & ~clr.sample_disagree;
          s_d.stat.frame_fault     = s_q.stat.frame_fault & ~clr.frame_fault;
        end
        ast_pkg::ADDR_DATA: begin
          s_d.tdr                  = wdata[8:0];
          s_d.stat.tx_buffer_empty = 1'b0;
          s_d.stat.tx_done         = 1'b0;
        end
        ast_pkg::ADDR_BAUD: begin
          s_d.baud = wdata[BW-1:0];
        end
      endcase
    end

    if (rd) begin
      unique case (addr)
        ast_pkg::ADDR_CTRL: s_d.rdata = {8'h00, s_q.ctrl};
        ast_pkg::ADDR_STAT: s_d.rdata = {10'h000, s_q.stat};
        ast_pkg::ADDR_DATA: s_d.rdata = {7'h00, s_q.rbuf};
        ast_pkg::ADDR_BAUD: s_d.rdata = {{(ast_pkg::DW-BW){1'b0}}, s_q.baud};
      endcase
      if (addr == ast_pkg::ADDR_DATA) begin
        s_d.stat.rx_buffer_full = 1'b0;
      end
    end

    if (!s_q.ctrl.tx_on && s_d.ctrl.tx_on) begin
      s_d.idle_q = 1'b1;
    end
    if (s_q.ctrl.break_request && !s_d.ctrl.break_request) begin
      s_d.brk_q = 1'b1;
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    // sixteen ticks per bit
    if (tick) begin
      s_d.tsub = s_q.tsub + 4'h1;
      if (s_q.tsub == ast_pkg::SLOT_LAST) begin
        if (s_q.tleft > 4'h1) begin
          s_d.tsh   = {s_q.tfill, s_q.tsh[11:1]};
          s_d.tleft = s_q.tleft - 4'h1;
        end else begin
          s_d.tleft = '0;
          if (s_d.brk_q) begin
            tx_load_brk      = 1'b1;
            s_d.tsh          = '0;
            s_d.tfill        = 1'b0;
            s_d.tleft        = frame_len(s_q.ctrl)
                               + (s_q.ctrl.long_break ? ast_pkg::BREAK_EXTRA : 4'h0);
            s_d.brk_q        = s_d.ctrl.break_request;
            s_d.stat.tx_done = 1'b0;
          end else if (s_d.idle_q) begin
            s_d.tsh          = '1;
            s_d.tfill        = 1'b1;
            s_d.tleft        = frame_len(s_q.ctrl);
            s_d.idle_q       = 1'b0;
            s_d.stat.tx_done = 1'b0;
          end else if (s_q.ctrl.tx_on && !s_q.stat.tx_buffer_empty) begin
            // start low, data LSB first, stops high
            tx_load_data     = 1'b1;
            s_d.tsh          = s_q.ctrl.wide_char ? {2'h3, s_q.tdr, 1'b0}
                                                  : {3'h7, s_q.tdr[7:0], 1'b0};
            s_d.tfill        = 1'b1;
            s_d.tleft        = frame_len(s_q.ctrl);
            s_d.stat.tx_done = 1'b0;
            if (!data_wr) begin
              s_d.stat.tx_buffer_empty = 1'b1;
            end
          end else if (s_q.tleft == 4'h1) begin
            s_d.stat.tx_done = 1'b1;
          end
        end
      end
    end

    s_d.txd    = ((s_d.tleft != '0) ? s_d.tsh[0] : 1'b1) ^ s_d.ctrl.tx_polarity_flip;
    // pin held until pending frames end
    s_d.txd_oe = s_d.ctrl.tx_on | (s_d.tleft != '0) | s_d.idle_q | s_d.brk_q;

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    // receive enable
    if (!s_q.ctrl.rx_on) begin
      s_d.rxs = ast_pkg::AST_RX_IDLE;
    end else if (tick) begin
      s_d.hist = {s_q.hist[1:0], rxi};
      s_d.rsub = s_q.rsub + 4'h1;
      unique case (s_q.rxs)
        ast_pkg::AST_RX_IDLE: begin
          if (fall) begin
            s_d.rxs   = ast_pkg::AST_RX_START;
            s_d.rsub  = ast_pkg::SLOT_FIRST + 4'h1;
            s_d.lows  = '0;
            s_d.noise = 1'b0;
          end
        end
        ast_pkg::AST_RX_START: begin
          if (s_q.rsub == ast_pkg::SLOT_START_A || s_q.rsub == ast_pkg::SLOT_START_B
              || s_q.rsub == ast_pkg::SLOT_START_C) begin
            if (rxi) begin
              s_d.noise = 1'b1;
            end else begin
              s_d.lows = s_q.lows + 2'h1;
            end
            if (s_q.rsub == ast_pkg::SLOT_START_C && s_d.lows < ast_pkg::LOWS_MIN) begin
              start_fail = 1'b1;
              s_d.rxs    = ast_pkg::AST_RX_IDLE;
            end
          end else if (s_q.rsub >= ast_pkg::SLOT_BIT_A && s_q.rsub <= ast_pkg::SLOT_BIT_C
                       && rxi) begin
            // start stays low, only noise noted
            s_d.noise = 1'b1;
          end
          if (s_q.rsub == ast_pkg::SLOT_LAST) begin
            s_d.rxs  = ast_pkg::AST_RX_FRAME;
            s_d.ridx = 4'h1;
          end
        end
        ast_pkg::AST_RX_FRAME: begin
          if (fall) begin
            s_d.rsub = ast_pkg::SLOT_FIRST + 4'h1;
            if (s_q.rsub > ast_pkg::SLOT_BIT_C) begin
              s_d.ridx = s_q.ridx + 4'h1;
            end
          end else begin
            if (s_q.rsub == ast_pkg::SLOT_BIT_A || s_q.rsub == ast_pkg::SLOT_BIT_B) begin
              s_d.votes = {s_q.votes[1:0], rxi};
            end
            if (s_q.rsub == ast_pkg::SLOT_BIT_C) begin
              bit_v = maj3({s_q.votes[1:0], rxi});
              if ({s_q.votes[1:0], rxi} != {3{bit_v}}) begin
                s_d.noise = 1'b1;
              end
              if (s_q.ridx <= ast_pkg::DATA_BASE + {3'h0, s_q.ctrl.wide_char}) begin
                s_d.rsh = {bit_v, s_q.rsh[8:1]};
              end else begin
                rx_done = 1'b1;
              end
            end
            if (s_q.rsub == ast_pkg::SLOT_LAST) begin
              s_d.ridx = s_q.ridx + 4'h1;
            end
          end
        end
        default: begin
          s_d.rxs = ast_pkg::AST_RX_IDLE;
        end
      endcase
    end

    if (rx_done) begin
      s_d.rxs = ast_pkg::AST_RX_IDLE;
      ch      = s_q.ctrl.wide_char ? s_q.rsh : {1'b0, s_q.rsh[8:1]};
      if (!s_q.stat.frame_fault) begin
        if (s_q.stat.rx_buffer_full) begin
          s_d.stat.overrun = 1'b1;
        end else begin
          s_d.rbuf                 = ch;
          s_d.stat.rx_buffer_full  = 1'b1;
          s_d.stat.sample_disagree = s_q.stat.sample_disagree | s_d.noise;
          s_d.stat.frame_fault     = !bit_v;
        end
      end
      if (!bit_v && ch != '0) begin
        s_d.hist = ast_pkg::HIGHS3;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q        <= '0;
      s_q.ctrl   <= ast_pkg::CTRL_RST;
      s_q.stat   <= ast_pkg::STAT_RST;
      s_q.baud   <= BW'(ast_pkg::BAUD_RST);
      s_q.txd    <= 1'b1;
      s_q.rxs    <= ast_pkg::AST_RX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata  = s_q.rdata;
  assign txd    = s_q.txd;
  assign txd_oe = s_q.txd_oe;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence seq_rx_arm;
    s_q.rxs == ast_pkg::AST_RX_IDLE ##1 s_q.rxs == ast_pkg::AST_RX_START;
  endsequence

  a_tx_idle_level: assert property (
    (s_q.tleft == '0 && $stable(s_q.ctrl)) |-> txd == !s_q.ctrl.tx_polarity_flip)
    else $error("idle output level wrong");
  a_preamble_queue: assert property (
    $rose(s_q.ctrl.tx_on) |-> (s_q.idle_q || s_q.tleft != '0))
    else $error("enable did not queue preamble");
  a_tx_frame_len: assert property (
    tx_load_data |=> s_q.tleft == frame_len($past(s_q.ctrl)) && s_q.tsh[0] == 1'b0)
    else $error("data frame length wrong");
  a_tx_buffer_empty_on_load: assert property (
    (tx_load_data && !data_wr) |=> s_q.stat.tx_buffer_empty)
    else $error("buffer empty flag not set");
  a_tx_done_idle: assert property (
    s_q.stat.tx_done |-> s_q.tleft == '0)
    else $error("done while shifting");
  a_pin_kept: assert property (
    s_q.tleft != '0 |-> txd_oe)
    else $error("pin released mid frame");
  a_break_zeros: assert property (
    tx_load_brk |=> s_q.tsh == '0 && !s_q.tfill && s_q.tleft >= ast_pkg::FRAME_BASE)
    else $error("break frame not all zero");
  a_start_reject: assert property (
    start_fail |=> s_q.rxs == ast_pkg::AST_RX_IDLE)
    else $error("false start accepted");
  a_edge_highs: assert property (
    seq_rx_arm |-> $past(s_q.hist) == ast_pkg::HIGHS3)
    else $error("start without three highs");
  a_overrun_set: assert property (
    (rx_done && s_q.stat.rx_buffer_full && !s_q.stat.frame_fault)
      |=> s_q.stat.overrun && $stable(s_q.rbuf))
    else $error("overrun not flagged");
  a_fault_block: assert property (
    (rx_done && s_q.stat.frame_fault) |=> $stable(s_q.rbuf))
    else $error("load during frame fault");

endmodule

// ===== ast_remote.sv
// Remote serial device model: sends frames into rxd and decodes frames seen on txd.
// Assumes one bit time is bit_len mclk cycles; the line idles high unless inverted.
`timescale 1ns/100ps
module ast_remote (
  input  wire logic       mclk,
  input  wire logic       txd,
  input  wire logic       tx_inv,
  input  wire logic [3:0] rx_bits,
  output logic            rxd
);
  int         bit_len = 16;
  logic [9:0] got_q[$];

  initial rxd = 1'b1;

  // ----------------------------------------
  // Sender
  // ----------------------------------------
  // Low start, LSB first, stop level
  // Bad stop and a one-cycle glitch are only sent when the bench asks for them
  task automatic send(input logic [8:0] d, input int nb, input logic stop,
                      input logic inv, input int glitch);
    logic lvl;
    int   c;
    c = 0;
    for (int b = -1; b <= nb + 2; b++) begin
      lvl = (b == 0) ? 1'b0 : (b > 0 && b <= nb) ? d[b-1] : (b == nb + 1) ? stop : 1'b1;
      repeat (bit_len) begin
        @(posedge mclk);
        rxd <= lvl ^ inv ^ (c == glitch);
        c++;
      end
    end
  endtask

  task automatic low_pulse(input int n);
    @(posedge mclk);
    rxd <= 1'b0;
    repeat (n) @(posedge mclk);
    rxd <= 1'b1;
  endtask

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  // Samples mid-bit, LSB first, stop kept above the data
  always begin
    logic [9:0] v;
    @(posedge mclk);
    if ((txd ^ tx_inv) === 1'b0) begin
      v = 10'h000;
      repeat (bit_len / 2) @(posedge mclk);
      for (int i = 0; i <= int'(rx_bits); i++) begin
        repeat (bit_len) @(posedge mclk);
        v[i] = txd ^ tx_inv;
      end
      got_q.push_back(v);
      while ((txd ^ tx_inv) !== 1'b1) @(posedge mclk);
    end
  end
endmodule

// ===== test_ast_core.sv
// Self-checking bench for the serial core: register tasks plus a remote serial model.
// Assumes baud modulus 1, so one bit time is 16 mclk cycles.
`timescale 1ns/100ps
module test_ast_core;
  logic        mclk;
  logic        rst;
  logic [1:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        rxd;
  logic        txd;
  logic        txd_oe;
  logic        tx_inv;
  logic [3:0]  rx_bits;
  logic [15:0] v;
  logic [9:0]  g;
  int          bad_count;
  int          compares;
  int          cyc;
  int          brk_len[4] = '{10, 13, 11, 15};
  logic [7:0]  brk_cfg[4] = '{8'h00, 8'h20, 8'h40, 8'hE0};

  ast_core uut (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .rxd, .txd, .txd_oe);
  ast_remote remote (.mclk, .txd, .tx_inv, .rx_bits, .rxd);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic wreg(input logic [1:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rreg(input logic [1:0] a);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    @(negedge mclk);
    v = rdata;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_got();
    cyc = 0;
    while (remote.got_q.size() == 0 && cyc < 3000) begin
      @(posedge mclk);
      cyc++;
    end
    g = (cyc < 3000) ? remote.got_q.pop_front() : 10'h000;
  endtask

  task automatic poll_empty();
    v = 16'h0000;
    for (int k = 0; k < 100 && v[0] !== 1'b1; k++) rreg(ast_pkg::ADDR_STAT);
  endtask

  task automatic rx_got(input logic [8:0] d);
    rreg(ast_pkg::ADDR_STAT);
    check("rx_full", {15'h0000, v[2]}, 16'h0001);
    rreg(ast_pkg::ADDR_DATA);
    check("rx_data", {7'h00, v[8:0]}, {7'h00, d});
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // A hang costs a mismatch; the tests need about 5000 cycles, this allows 20000
  initial begin
    #400000;
    bad_count++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    addr = 2'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    tx_inv = 1'b0;
    rx_bits = 4'h8;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    check("txd_idle", {15'h0000, txd}, 16'h0001);
    check("txd_oe", {15'h0000, txd_oe}, 16'h0000);
    rreg(ast_pkg::ADDR_CTRL);
    check("ctrl_rst", v, 16'h0000);
    rreg(ast_pkg::ADDR_STAT);
    check("stat_rst", v, 16'h0003);
    rreg(ast_pkg::ADDR_BAUD);
    check("baud_rst", v, 16'h001A);
    wreg(ast_pkg::ADDR_BAUD, 16'h0001);
    remote.send(9'h099, 8, 1'b1, 1'b0, -1);
    rreg(ast_pkg::ADDR_STAT);
    check("rx_off", {15'h0000, v[2]}, 16'h0000);
    $display("Finished reset and idle checks");

    wreg(ast_pkg::ADDR_CTRL, 16'h0003);
    wreg(ast_pkg::ADDR_DATA, 16'h00A5);
    wait_got();
    check("preamble", {15'h0000, (cyc >= 300)}, 16'h0001);
    check("tx_frame", {6'h00, g}, 16'h01A5);
    repeat (40) @(posedge mclk);
    rreg(ast_pkg::ADDR_STAT);
    check("tx_done", {14'h0000, v[1:0]}, 16'h0003);
    wreg(ast_pkg::ADDR_DATA, 16'h0011);
    poll_empty();
    wreg(ast_pkg::ADDR_DATA, 16'h0022);
    poll_empty();
    check("buf_empty", {15'h0000, v[0]}, 16'h0001);
    wreg(ast_pkg::ADDR_CTRL, 16'h0002);
    wait_got();
    check("tx_first", {6'h00, g}, 16'h0111);
    wait_got();
    check("tx_second", {6'h00, g}, 16'h0122);
    check("oe_held", {15'h0000, txd_oe}, 16'h0001);
    repeat (40) @(posedge mclk);
    check("oe_freed", {15'h0000, txd_oe}, 16'h0000);
    $display("Finished transmit checks");

    wreg(ast_pkg::ADDR_CTRL, 16'h0003);
    remote.send(9'h03C, 8, 1'b1, 1'b0, -1);
    rx_got(9'h03C);
    remote.send(9'h011, 8, 1'b1, 1'b0, -1);
    remote.send(9'h022, 8, 1'b1, 1'b0, -1);
    rreg(ast_pkg::ADDR_STAT);
    check("overrun", {15'h0000, v[3]}, 16'h0001);
    rreg(ast_pkg::ADDR_DATA);
    check("kept_first", {7'h00, v[8:0]}, 16'h0011);
    wreg(ast_pkg::ADDR_STAT, 16'h0038);
    remote.send(9'h05A, 8, 1'b1, 1'b0, 72);
    rreg(ast_pkg::ADDR_STAT);
    check("noise", {15'h0000, v[4]}, 16'h0001);
    rreg(ast_pkg::ADDR_DATA);
    check("noisy_data", {7'h00, v[8:0]}, 16'h005A);
    wreg(ast_pkg::ADDR_STAT, 16'h0038);
    remote.low_pulse(2);
    repeat (200) @(posedge mclk);
    rreg(ast_pkg::ADDR_STAT);
    check("false_start", {15'h0000, v[2]}, 16'h0000);
    remote.send(9'h077, 8, 1'b0, 1'b0, -1);
    rreg(ast_pkg::ADDR_STAT);
    check("frame_fault", {10'h000, v[5:0]}, 16'h0027);
    rreg(ast_pkg::ADDR_DATA);
    check("fault_data", {7'h00, v[8:0]}, 16'h0077);
    // Preloaded highs let the low stop tail open a new frame; let it run out
    repeat (200) @(posedge mclk);
    remote.send(9'h044, 8, 1'b1, 1'b0, -1);
    rreg(ast_pkg::ADDR_STAT);
    check("fault_block", {15'h0000, v[2]}, 16'h0000);
    wreg(ast_pkg::ADDR_STAT, 16'h0038);
    remote.send(9'h044, 8, 1'b1, 1'b0, -1);
    rx_got(9'h044);
    wreg(ast_pkg::ADDR_CTRL, 16'h000B);
    remote.send(9'h0C3, 8, 1'b1, 1'b1, -1);
    rx_got(9'h0C3);
    $display("Finished receive checks");

    for (int k = 0; k < 4; k++) begin
      wreg(ast_pkg::ADDR_CTRL, {8'h00, brk_cfg[k]} | 16'h001B);
      wreg(ast_pkg::ADDR_CTRL, {8'h00, brk_cfg[k]} | 16'h000B);
      cyc = 0;
      while (txd !== 1'b0 && cyc < 400) begin
        @(posedge mclk);
        cyc++;
      end
      cyc = 0;
      while (txd === 1'b0 && cyc < 400) begin
        @(posedge mclk);
        cyc++;
      end
      check("break_len", cyc[15:0], 16'(brk_len[k] * 16));
    end
    $display("Finished break checks");

    // Partner may have locked onto the flipped idle level; let it settle first
    wreg(ast_pkg::ADDR_CTRL, 16'h004F);
    repeat (200) @(posedge mclk);
    check("txd_flip", {15'h0000, txd}, 16'h0000);
    remote.got_q.delete();
    tx_inv <= 1'b1;
    rx_bits <= 4'h9;
    repeat (20) @(posedge mclk);
    wreg(ast_pkg::ADDR_DATA, 16'h01A5);
    wait_got();
    check("wide_frame", {6'h00, g}, 16'h03A5);
    $display("Finished polarity and width checks");
    tally_and_finish();
  end
endmodule
